// [rtl/loop_cfg_pkg.sv]
// Package for the loop path configuration register block.
// Assumes a classic Wishbone slave with 32-bit data and byte addressing.
package loop_cfg_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_SYNC_EN      = 8'h63;
  localparam logic [7:0] IDX_SEC_FREQ     = 8'h64;
  localparam logic [7:0] IDX_MAIN_FREQ    = 8'h65;
  localparam logic [7:0] IDX_SEC_BW       = 8'h66;
  localparam logic [7:0] IDX_MAIN_LCK_BW  = 8'h67;
  localparam logic [7:0] IDX_MAIN_ACQ_BW  = 8'h69;
  localparam logic [7:0] IDX_SEC_DAMP     = 8'h6A;
  localparam logic [7:0] IDX_MAIN_DAMP    = 8'h6B;
  localparam logic [7:0] IDX_SEC_GAIN     = 8'h6C;
  localparam logic [7:0] IDX_MAIN_GAIN    = 8'h6D;
  localparam logic [7:0] IDX_LOOP_STATE   = 8'h6E;

  // Writable bits per register
  localparam logic [7:0] MSK_SYNC_EN = 8'hC0;
  localparam logic [7:0] MSK_FREQ    = 8'h07;
  localparam logic [7:0] MSK_MAIN_FR = 8'h77;
  localparam logic [7:0] MSK_SEC_BW  = 8'h03;
  localparam logic [7:0] MSK_BW4     = 8'h0F;
  localparam logic [7:0] MSK_DAMP    = 8'h77;
  localparam logic [7:0] MSK_GAIN    = 8'hF7;

  // Values after reset
  localparam logic [7:0] RST_SYNC_EN  = 8'hC0;
  localparam logic [7:0] RST_SEC_FREQ = 8'h05;
  localparam logic [7:0] RST_MAIN_FR  = 8'h01;
  localparam logic [7:0] RST_SEC_BW   = 8'h00;
  localparam logic [7:0] RST_LCK_BW   = 8'h0B;
  localparam logic [7:0] RST_ACQ_BW   = 8'h0F;
  localparam logic [7:0] RST_DAMP     = 8'h13;
  localparam logic [7:0] RST_GAIN     = 8'hC2;

  // Field positions
  localparam int POS_MFR_EN  = 7;
  localparam int POS_FR_EN   = 6;
  localparam int POS_SRC_SEL = 6;
  localparam int POS_GAIN_EN = 7;

  localparam logic [1:0] SEC_BW_BAD = 2'h3;

  typedef enum logic [1:0] {
    LOCK_DIGITAL   = 2'b00,
    LOCK_ANALOG    = 2'b01,
    LOCK_ANALOG_8K = 2'b10
  } lock_mode_t;

  // Settings handed to the loop datapath
  typedef struct packed {
    logic [2:0] main_freq;
    logic [2:0] sec_freq;
    logic [1:0] main_to_sec_freq;
    logic       sec_apll_from_main;
    logic [1:0] sec_bw;
    logic [3:0] main_bw;
    logic       main_bw_valid;
    logic [2:0] main_damping;
    logic [2:0] sec_damping;
    logic       main_pd2_on;
    logic [2:0] main_pd2_gain;
    logic       sec_pd2_on;
    logic [2:0] sec_pd2_gain;
  } loop_cfg_t;

endpackage

// [rtl/loop_cfg_regs.sv]
// Loop path configuration registers and the settings they steer.
// Assumes a classic Wishbone master; loop state inputs arrive from
// datapath logic on sys_clk, sync pulses likewise.
// How it works
// - Sync outputs driven only when enable set
// - Main frequency field sets main loop rate
// - Source bit picks secondary APLL feed
// - Secondary bandwidth 18/35/70 Hz, 11 invalid
// - Acquisition bandwidth used while acquiring
// - Locked bandwidth used while phase locked
// - Secondary detector-2 gain auto or unused
// - Main detector-2 gain auto or unused
// - Low-rate analog gain only at 8k auto
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
module loop_cfg_regs
  import loop_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Loop status from datapath
  input  wire logic        main_locked,
  input  wire lock_mode_t  main_lock_mode,
  input  wire lock_mode_t  sec_lock_mode,
  // Raw sync pulses from dividers
  input  wire logic        frame_sync_raw,
  input  wire logic        multiframe_sync_raw,
  // Gated sync outputs with enables
  output logic             frame_sync_output,
  output logic             frame_sync_output_oe,
  output logic             multiframe_sync_output,
  output logic             multiframe_sync_output_oe,
  // Settings to the loops
  output loop_cfg_t        cfg
);

  logic [7:0] sync_en_r, sync_en_nxt;
  logic [7:0] sec_freq_r, sec_freq_nxt;
  logic [7:0] main_freq_r, main_freq_nxt;
  logic [7:0] sec_bw_r, sec_bw_nxt;
  logic [7:0] lck_bw_r, lck_bw_nxt;
  logic [7:0] acq_bw_r, acq_bw_nxt;
  logic [7:0] sec_damp_r, sec_damp_nxt;
  logic [7:0] main_damp_r, main_damp_nxt;
  logic [7:0] sec_gain_r, sec_gain_nxt;
  logic [7:0] main_gain_r, main_gain_nxt;
  logic       ack_r, ack_nxt;
  logic       err_r, err_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic       fr_r, fr_nxt;
  logic       mfr_r, mfr_nxt;
  loop_cfg_t  cfg_r, cfg_nxt;

  // Merge a write under mask; masked-off bits stay zero
  function automatic logic [7:0] wmerge(input logic [7:0] old, input logic [7:0] wd,
                                        input logic [7:0] msk);
    wmerge = wd & msk;
  endfunction

  // Valid 4-bit bandwidth codes run 1000..1111, 0000, 0001
  function automatic logic bw_code_ok(input logic [3:0] code);
    bw_code_ok = code[3] | (code[3:1] == 3'h0);
  endfunction

  // Detector-2 gain by locking mode; zero width gain means unused
  function automatic logic [2:0] pd2_gain(input logic [7:0] gain_reg,
                                          input logic [7:0] damp_reg,
                                          input lock_mode_t mode);
    case (mode)
      LOCK_ANALOG:    pd2_gain = gain_reg[6:4];
      LOCK_ANALOG_8K: pd2_gain = damp_reg[6:4];
      default:        pd2_gain = gain_reg[2:0];
    endcase
  endfunction

  logic       req;
  logic       hit;
  logic [7:0] idx;
  logic [7:0] rbyte;
  logic       wr;

  assign req = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
  assign idx = wb_adr_i[9:2];
  // Write lands on the ack edge, where the master samples the answer
  assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & ack_r;

  always_comb begin
    hit   = 1'b1;
    rbyte = 8'h00;
    case (idx)
      IDX_SYNC_EN:     rbyte = sync_en_r;
      IDX_SEC_FREQ:    rbyte = sec_freq_r;
      IDX_MAIN_FREQ:   rbyte = main_freq_r;
      IDX_SEC_BW:      rbyte = sec_bw_r;
      IDX_MAIN_LCK_BW: rbyte = lck_bw_r;
      IDX_MAIN_ACQ_BW: rbyte = acq_bw_r;
      IDX_SEC_DAMP:    rbyte = sec_damp_r;
      IDX_MAIN_DAMP:   rbyte = main_damp_r;
      IDX_SEC_GAIN:    rbyte = sec_gain_r;
      IDX_MAIN_GAIN:   rbyte = main_gain_r;
      IDX_LOOP_STATE:  rbyte = {3'h0, bw_code_ok(cfg_r.main_bw), sec_lock_mode,
                                main_lock_mode[0], main_locked};
      default:         hit   = 1'b0;
    endcase
  end

  // Per-register write strobes; one decode shared by all groups
  logic we_sync_en, we_sec_freq, we_main_freq, we_sec_bw, we_lck_bw;
  logic we_acq_bw, we_sec_damp, we_main_damp, we_sec_gain, we_main_gain;

  always_comb begin
    we_sync_en   = 1'b0;
    we_sec_freq  = 1'b0;
    we_main_freq = 1'b0;
    we_sec_bw    = 1'b0;
    we_lck_bw    = 1'b0;
    we_acq_bw    = 1'b0;
    we_sec_damp  = 1'b0;
    we_main_damp = 1'b0;
    we_sec_gain  = 1'b0;
    we_main_gain = 1'b0;
    if (wr) begin
      case (idx)
        IDX_SYNC_EN:     we_sync_en   = 1'b1;
        IDX_SEC_FREQ:    we_sec_freq  = 1'b1;
        IDX_MAIN_FREQ:   we_main_freq = 1'b1;
        IDX_SEC_BW:      we_sec_bw    = 1'b1;
        IDX_MAIN_LCK_BW: we_lck_bw    = 1'b1;
        IDX_MAIN_ACQ_BW: we_acq_bw    = 1'b1;
        IDX_SEC_DAMP:    we_sec_damp  = 1'b1;
        IDX_MAIN_DAMP:   we_main_damp = 1'b1;
        IDX_SEC_GAIN:    we_sec_gain  = 1'b1;
        IDX_MAIN_GAIN:   we_main_gain = 1'b1;
        default:         we_sync_en   = 1'b0;
      endcase
    end
  end

  // Output enables and loop frequencies
  always_comb begin
    sync_en_nxt   = sync_en_r;
    sec_freq_nxt  = sec_freq_r;
    main_freq_nxt = main_freq_r;
    if (we_sync_en) begin
      sync_en_nxt = wmerge(sync_en_r, wb_dat_i[7:0], MSK_SYNC_EN);
    end
    if (we_sec_freq) begin
      sec_freq_nxt = wmerge(sec_freq_r, wb_dat_i[7:0], MSK_FREQ);
    end
    if (we_main_freq) begin
      main_freq_nxt = wmerge(main_freq_r, wb_dat_i[7:0], MSK_MAIN_FR);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync_en_r   <= RST_SYNC_EN;
      sec_freq_r  <= RST_SEC_FREQ;
      main_freq_r <= RST_MAIN_FR;
    end else begin
      sync_en_r   <= sync_en_nxt;
      sec_freq_r  <= sec_freq_nxt;
      main_freq_r <= main_freq_nxt;
    end
  end

  // Loop bandwidths
  always_comb begin
    sec_bw_nxt = sec_bw_r;
    lck_bw_nxt = lck_bw_r;
    acq_bw_nxt = acq_bw_r;
    if (we_sec_bw) begin
      sec_bw_nxt = wmerge(sec_bw_r, wb_dat_i[7:0], MSK_SEC_BW);
    end
    if (we_lck_bw) begin
      lck_bw_nxt = wmerge(lck_bw_r, wb_dat_i[7:0], MSK_BW4);
    end
    if (we_acq_bw) begin
      acq_bw_nxt = wmerge(acq_bw_r, wb_dat_i[7:0], MSK_BW4);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sec_bw_r <= RST_SEC_BW;
      lck_bw_r <= RST_LCK_BW;
      acq_bw_r <= RST_ACQ_BW;
    end else begin
      sec_bw_r <= sec_bw_nxt;
      lck_bw_r <= lck_bw_nxt;
      acq_bw_r <= acq_bw_nxt;
    end
  end

  // Damping and detector-2 gains
  always_comb begin
    sec_damp_nxt  = sec_damp_r;
    main_damp_nxt = main_damp_r;
    sec_gain_nxt  = sec_gain_r;
    main_gain_nxt = main_gain_r;
    if (we_sec_damp) begin
      sec_damp_nxt = wmerge(sec_damp_r, wb_dat_i[7:0], MSK_DAMP);
    end
    if (we_main_damp) begin
      main_damp_nxt = wmerge(main_damp_r, wb_dat_i[7:0], MSK_DAMP);
    end
    if (we_sec_gain) begin
      sec_gain_nxt = wmerge(sec_gain_r, wb_dat_i[7:0], MSK_GAIN);
    end
    if (we_main_gain) begin
      main_gain_nxt = wmerge(main_gain_r, wb_dat_i[7:0], MSK_GAIN);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sec_damp_r  <= RST_DAMP;
      main_damp_r <= RST_DAMP;
      sec_gain_r  <= RST_GAIN;
      main_gain_r <= RST_GAIN;
    end else begin
      sec_damp_r  <= sec_damp_nxt;
      main_damp_r <= main_damp_nxt;
      sec_gain_r  <= sec_gain_nxt;
      main_gain_r <= main_gain_nxt;
    end
  end

  // Bus answer: one cycle after the request, unmapped gets err
  always_comb begin
    ack_nxt  = req & hit;
    err_nxt  = req & ~hit;
    rdat_nxt = rdat_r;
    if (req) begin
      rdat_nxt = {24'h000000, rbyte};
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ack_r  <= 1'b0;
      err_r  <= 1'b0;
      rdat_r <= 32'h00000000;
    end else begin
      ack_r  <= ack_nxt;
      err_r  <= err_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;
  assign wb_dat_o = rdat_r;

  // Settings computed from registers and loop state
  always_comb begin
    cfg_nxt           = cfg_r;
    cfg_nxt.main_freq = main_freq_r[2:0];
    cfg_nxt.sec_freq  = sec_freq_r[2:0];
    cfg_nxt.main_to_sec_freq   = main_freq_r[5:4];
    cfg_nxt.sec_apll_from_main = main_freq_r[POS_SRC_SEL];
    // Invalid code keeps the last good bandwidth rather than guessing
    if (sec_bw_r[1:0] != SEC_BW_BAD) begin
      cfg_nxt.sec_bw = sec_bw_r[1:0];
    end
    if (main_locked) begin
      cfg_nxt.main_bw = lck_bw_r[3:0];
    end else begin
      cfg_nxt.main_bw = acq_bw_r[3:0];
    end
    cfg_nxt.main_bw_valid = bw_code_ok(cfg_nxt.main_bw);
    cfg_nxt.main_damping  = main_damp_r[2:0];
    cfg_nxt.sec_damping   = sec_damp_r[2:0];
    cfg_nxt.sec_pd2_on    = sec_gain_r[POS_GAIN_EN];
    cfg_nxt.sec_pd2_gain  = sec_gain_r[POS_GAIN_EN]
                          ? pd2_gain(sec_gain_r, sec_damp_r, sec_lock_mode) : 3'h0;
    cfg_nxt.main_pd2_on   = main_gain_r[POS_GAIN_EN];
    cfg_nxt.main_pd2_gain = main_gain_r[POS_GAIN_EN]
                          ? pd2_gain(main_gain_r, main_damp_r, main_lock_mode) : 3'h0;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  assign cfg = cfg_r;

  // Sync outputs undriven while disabled, and held low from the cycle after the enable clears
  always_comb begin
    fr_nxt  = frame_sync_raw & sync_en_r[POS_FR_EN];
    mfr_nxt = multiframe_sync_raw & sync_en_r[POS_MFR_EN];
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fr_r  <= 1'b0;
      mfr_r <= 1'b0;
    end else begin
      fr_r  <= fr_nxt;
      mfr_r <= mfr_nxt;
    end
  end

  assign frame_sync_output         = fr_r;
  assign multiframe_sync_output    = mfr_r;
  assign frame_sync_output_oe      = sync_en_r[POS_FR_EN];
  assign multiframe_sync_output_oe = sync_en_r[POS_MFR_EN];

endmodule

// [verification/loop_cfg_regs_props.sv]
// Checker for the loop configuration register block.
// Assumes it is bound to loop_cfg_regs and sees its ports only.
`timescale 1ns/1ps
module loop_cfg_regs_props
  import loop_cfg_pkg::*;
(
  // Clock, reset and bus
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic [31:0] wb_dat_o,
  // Syncs and settings
  input wire logic        frame_sync_raw,
  input wire logic        multiframe_sync_raw,
  input wire logic        frame_sync_output,
  input wire logic        frame_sync_output_oe,
  input wire logic        multiframe_sync_output,
  input wire logic        multiframe_sync_output_oe,
  input wire loop_cfg_t   cfg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  AST_ANSWER:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
    else $error("request not answered");
  AST_ACK_PULSE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  AST_HIGH_ZERO:
    assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data not zero");
  // Guarded by past reset, the flops still held reset values then
  AST_FR_GATE:
    assert property ($past(rstn) |-> frame_sync_output ==
      ($past(frame_sync_raw) && $past(frame_sync_output_oe))) else $error("frame sync gate");
  AST_MFR_GATE:
    assert property (!multiframe_sync_output_oe [*2] |-> !multiframe_sync_output)
    else $error("multiframe sync while disabled");
  AST_SEC_BW:
    assert property (cfg.sec_bw != 2'h3) else $error("invalid secondary bandwidth applied");
  AST_PD2_MAIN:
    assert property (!cfg.main_pd2_on |-> cfg.main_pd2_gain == 3'h0) else $error("main gain");
  AST_PD2_SEC:
    assert property (!cfg.sec_pd2_on |-> cfg.sec_pd2_gain == 3'h0) else $error("sec gain");
  COV_ACK: cover property (wb_ack_o);
  COV_ERR: cover property (wb_err_o);
  COV_FR: cover property (frame_sync_output && multiframe_sync_output);
endmodule
bind loop_cfg_regs loop_cfg_regs_props u_props(.sys_clk, .rstn, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .wb_err_o, .wb_dat_o, .frame_sync_raw, .multiframe_sync_raw, .frame_sync_output,
  .frame_sync_output_oe, .multiframe_sync_output, .multiframe_sync_output_oe, .cfg);

// [verification/loop_cfg_regs_tb_top.sv]
// Self-checking bench for the loop configuration register block.
// Assumes no partner: bench drives bus, loop state and raw syncs.
`timescale 1ns/1ps
module loop_cfg_regs_tb_top import loop_cfg_pkg::*; ;
  logic sys_clk, rstn, cyc, stb, we, fr, mf, lk, ack, err, fso, fsoe, mso, msoe;
  logic [3:0]  sel;
  logic [9:0]  adr;
  logic [31:0] dat, dat_o;
  lock_mode_t  mm, sm;
  loop_cfg_t   cfg;
  logic [7:0]  ix[10] = '{8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h69, 8'h6A, 8'h6B, 8'h6C, 8'h6D};
  logic [7:0]  mk[10] = '{8'hC0, 8'h07, 8'h77, 8'h03, 8'h0F, 8'h0F, 8'h77, 8'h77, 8'hF7, 8'hF7};
  logic [7:0]  m[10] = '{8'hC0, 8'h05, 8'h01, 8'h00, 8'h0B, 8'h0F, 8'h13, 8'h13, 8'hC2, 8'hC2};
  logic [7:0]  rv[10] = '{8'hC0, 8'h05, 8'h01, 8'h00, 8'h0B, 8'h0F, 8'h13, 8'h13, 8'hC2, 8'hC2};
  logic [1:0]  sb = 2'h0;
  int          errors = 0, compares = 0, seed = 32'h2A76, j;

  loop_cfg_regs u_loop_cfg_regs(.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .wb_err_o(err), .main_locked(lk), .main_lock_mode(mm), .sec_lock_mode(sm),
    .frame_sync_raw(fr), .multiframe_sync_raw(mf), .frame_sync_output(fso),
    .frame_sync_output_oe(fsoe), .multiframe_sync_output(mso),
    .multiframe_sync_output_oe(msoe), .cfg(cfg));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Bandwidth codes run 1000 upward, wrapping through 0000 and 0001
  function automatic logic bwok(input logic [3:0] c);
    return (c >= 4'h8) || (c <= 4'h1);
  endfunction

  // One bus cycle; the model follows only writes that enabled byte lane 0
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    int n, p;
    logic hit;
    n = 0;
    p = -1;
    for (int k = 0; k < 10; k++) begin
      if (ix[k] == a) p = k;
    end
    hit = (p >= 0) || (a == IDX_LOOP_STATE);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {a, 2'b00};
    dat <= {24'h5A5A5A, d};
    sel <= s;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!ack && !err && n < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    chk({ack, err}, {hit, !hit});
    if (!w && p >= 0) chk(dat_o, m[p]);
    if (!w && a == IDX_LOOP_STATE) begin
      chk(dat_o, {3'h0, bwok(lk ? m[4][3:0] : m[5][3:0]), sm, mm[0], lk});
    end
    if (w && p >= 0 && s[0]) m[p] = (m[p] & ~mk[p]) | (d & mk[p]);
    if (w && p == 3 && s[0] && d[1:0] != 2'h3) sb = d[1:0];
  endtask

  function automatic logic [3:0] pg(input logic [7:0] g, input logic [7:0] d,
                                    input lock_mode_t md);
    if (!g[7]) return 4'h0;
    if (md == LOCK_DIGITAL) return {1'b1, g[2:0]};
    if (md == LOCK_ANALOG) return {1'b1, g[6:4]};
    return {1'b1, d[6:4]};
  endfunction

  task automatic cfgc;
    repeat (2) @(posedge sys_clk);
    chk(cfg.main_freq, m[2][2:0]);
    chk(cfg.sec_apll_from_main, m[2][6]);
    chk(cfg.main_to_sec_freq, m[2][5:4]);
    chk(cfg.sec_freq, m[1][2:0]);
    chk({cfg.main_damping, cfg.sec_damping}, {m[7][2:0], m[6][2:0]});
    chk(cfg.main_bw_valid, bwok(lk ? m[4][3:0] : m[5][3:0]));
    chk(cfg.sec_bw, sb);
    chk(cfg.main_bw, lk ? m[4][3:0] : m[5][3:0]);
    chk({cfg.main_pd2_on, cfg.main_pd2_gain}, pg(m[9], m[7], mm));
    chk({cfg.sec_pd2_on, cfg.sec_pd2_gain}, pg(m[8], m[6], sm));
  endtask

  task stop_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    {rstn, cyc, stb, we, fr, mf, lk} = '0;
    sel = '0;
    adr = '0;
    dat = '0;
    mm = LOCK_DIGITAL;
    sm = LOCK_DIGITAL;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int k = 0; k < 10; k++) acc(1'b0, ix[k], 8'h00, 4'hF);
    acc(1'b0, 8'h68, 8'h00, 4'hF);
    acc(1'b1, 8'h6F, 8'hFF, 4'hF);
    cfgc;
    $display("test reset and map done");
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, 8'h63, {k[1:0], 6'h3F}, 4'h1);
      repeat (6) begin
        @(posedge sys_clk);
        fr <= 1'($random(seed));
        mf <= 1'($random(seed));
        @(posedge sys_clk);
        #1;
        chk({fso, fsoe}, {fr & m[0][6], m[0][6]});
        chk({mso, msoe}, {mf & m[0][7], m[0][7]});
      end
    end
    $display("test sync gating done");
    acc(1'b1, 8'h66, 8'h02, 4'h1);
    acc(1'b1, 8'h66, 8'h03, 4'h1);
    cfgc;
    $display("test invalid bandwidth done");
    repeat (60) begin
      j = {$random(seed)} % 10;
      lk <= 1'($random(seed));
      mm <= lock_mode_t'(2'({$random(seed)} % 3));
      sm <= lock_mode_t'(2'({$random(seed)} % 3));
      acc(1'b1, ix[j], 8'($random(seed)), 4'($random(seed)));
      acc(1'b0, ix[j], 8'h00, 4'hF);
      cfgc;
      acc(1'b0, IDX_LOOP_STATE, 8'h00, 4'hF);
    end
    $display("test random access done");
    rstn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int k = 0; k < 10; k++) m[k] = rv[k];
    sb = 2'h0;
    for (int k = 0; k < 10; k++) acc(1'b0, ix[k], 8'h00, 4'hF);
    cfgc;
    $display("test mid-run reset done");
    stop_test;
  end

  initial begin
    #300000;
    errors++;
    stop_test;
  end
endmodule
